// ==== core/epw_consts.svh ====
`ifndef EPW_CONSTS_SVH
`define EPW_CONSTS_SVH

// command codes
`define EPW_CMD_RAM_WRITE 8'h24
`define EPW_CMD_GATE_WIDTH 8'h3A
`define EPW_CMD_BORDER 8'h3B
`define EPW_CMD_X_WINDOW 8'h44
`define EPW_CMD_Y_WINDOW 8'h45
`define EPW_CMD_X_COUNTER 8'h4E
`define EPW_CMD_Y_COUNTER 8'h4F

// reset values and field layout
`define EPW_GATE_WIDTH_RST 7'h0B
`define EPW_BORDER_RST 8'h01
`define EPW_BORDER_MASK 8'hF3
`define EPW_BORDER_FOLLOW_BIT 7
`define EPW_BORDER_FIX_BIT 6
`define EPW_X_START_RST 5'h00
`define EPW_X_END_RST 5'h0F
`define EPW_Y_START_RST 8'h00
`define EPW_Y_END_RST 8'hF9
`define EPW_X_COUNTER_RST 5'h00
`define EPW_Y_COUNTER_RST 8'h00
`define EPW_CTRL_INIT_STAGE_BIT 0

// register byte offsets
`define EPW_OFS_GATE_WIDTH 8'h00
`define EPW_OFS_BORDER 8'h04
`define EPW_OFS_X_WINDOW 8'h08
`define EPW_OFS_Y_WINDOW 8'h0C
`define EPW_OFS_ADDR_COUNTER 8'h10
`define EPW_OFS_STATUS 8'h14
`define EPW_OFS_CTRL 8'h18

// bus responses
`define EPW_RESP_OKAY 2'h0
`define EPW_RESP_SLVERR 2'h2

`endif

// ==== core/epw_pkg.sv ====
package epw_pkg;

   typedef enum logic [1:0] {
      PS_IDLE,
      PS_PARAM,
      PS_RAM
   } epw_parse_t;

   typedef enum logic [1:0] {
      BM_TRANSITION,
      BM_FIXED,
      BM_FOLLOW
   } epw_border_mode_t;

   typedef enum logic [2:0] {
      R_GATE,
      R_BORDER,
      R_XWIN,
      R_YWIN,
      R_ADDR,
      R_STATUS,
      R_CTRL,
      R_NONE
   } epw_reg_t;

   typedef struct packed {
      logic valid;
      logic isData;
      logic [7:0] data;
   } epw_host_byte_t;

   typedef struct packed {
      epw_border_mode_t mode;
      logic [1:0] level;
   } epw_border_t;

   typedef struct packed {
      logic en;
      logic [4:0] x;
      logic [7:0] y;
      logic [7:0] data;
   } epw_ram_wr_t;

   typedef struct packed {
      logic [4:0] xStart;
      logic [4:0] xEnd;
      logic [7:0] yStart;
      logic [7:0] yEnd;
   } epw_window_t;

endpackage

// ==== core/epw_addr_counter.sv ====
`timescale 1ns/100ps
`include "epw_consts.svh"

module epw_addr_counter (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire epw_pkg::epw_window_t window,
   input wire logic loadX,
   input wire logic loadY,
   input wire logic [7:0] loadValue,
   input wire logic advance,
   // counter state
   output logic [4:0] xCount,
   output logic [7:0] yCount
);

   logic [4:0] x_q, x_d;
   logic [7:0] y_q, y_d;

   always_comb begin
      x_d = x_q;
      y_d = y_q;
      if (loadX) begin
         x_d = loadValue[4:0];
      end
      if (loadY) begin
         y_d = loadValue;
      end
      // x runs first; reaching the window end wraps x and steps y
      if (advance) begin
         if (x_q == window.xEnd) begin
            x_d = window.xStart;
            y_d = (y_q == window.yEnd) ? window.yStart : y_q + 8'h01;
         end else begin
            x_d = x_q + 5'h01;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         x_q <= `EPW_X_COUNTER_RST;
         y_q <= `EPW_Y_COUNTER_RST;
      end else begin
         x_q <= x_d;
         y_q <= y_d;
      end
   end

   assign xCount = x_q;
   assign yCount = y_q;

endmodule

// ==== core/epw_cmd_decoder.sv ====
`timescale 1ns/100ps
`include "epw_consts.svh"

// Contract
// - 0x3A takes gate width, default 0x0B
// - 0x3B border byte; bit7 follows source initially
// - bit6 picks transition or fixed level
// - bits1:0 pick transition, reset 01
// - 0x44 sets X window, reset 00/0F
// - 0x45 sets Y window, reset 00/F9
// - 0x4E loads X counter, reset zero
// - 0x4F loads Y counter, reset zero
// - RAM data advances pointers until next command
module epw_cmd_decoder (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // received serial bytes
   input wire epw_pkg::epw_host_byte_t hostByte,
   // display side
   input wire logic [1:0] sourceLevel,
   output epw_pkg::epw_border_t borderDriveOutput,
   output epw_pkg::epw_ram_wr_t ramWrite,
   output logic [6:0] gateLineWidth,
   output epw_pkg::epw_window_t window,
   // axi4-lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   function automatic epw_pkg::epw_reg_t regSel(input logic [7:0] addr);
      epw_pkg::epw_reg_t sel;
      sel = epw_pkg::R_NONE;
      unique case (addr)
         `EPW_OFS_GATE_WIDTH: sel = epw_pkg::R_GATE;
         `EPW_OFS_BORDER: sel = epw_pkg::R_BORDER;
         `EPW_OFS_X_WINDOW: sel = epw_pkg::R_XWIN;
         `EPW_OFS_Y_WINDOW: sel = epw_pkg::R_YWIN;
         `EPW_OFS_ADDR_COUNTER: sel = epw_pkg::R_ADDR;
         `EPW_OFS_STATUS: sel = epw_pkg::R_STATUS;
         `EPW_OFS_CTRL: sel = epw_pkg::R_CTRL;
         default: sel = epw_pkg::R_NONE;
      endcase
      return sel;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // command parser state

   epw_pkg::epw_parse_t state_q, state_d;
   logic [7:0] cmd_q, cmd_d;
   logic [1:0] paramIdx_q, paramIdx_d;
   logic [6:0] gate_q, gate_d;
   logic [7:0] border_q, border_d;
   epw_pkg::epw_window_t win_q, win_d;
   epw_pkg::epw_ram_wr_t ramWr_q, ramWr_d;
   logic loadX, loadY, advance;
   logic [4:0] xCount;
   logic [7:0] yCount;

   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      paramIdx_d = paramIdx_q;
      gate_d = gate_q;
      border_d = border_q;
      win_d = win_q;
      ramWr_d = '0;
      loadX = 1'b0;
      loadY = 1'b0;
      advance = 1'b0;
      if (hostByte.valid && !hostByte.isData) begin
         // any command ends a ram write burst
         cmd_d = hostByte.data;
         paramIdx_d = 2'd0;
         state_d = (hostByte.data == `EPW_CMD_RAM_WRITE) ?
            epw_pkg::PS_RAM : epw_pkg::PS_PARAM;
      end else if (hostByte.valid) begin
         unique case (state_q)
            epw_pkg::PS_RAM: begin
               ramWr_d.en = 1'b1;
               ramWr_d.x = xCount;
               ramWr_d.y = yCount;
               ramWr_d.data = hostByte.data;
               advance = 1'b1;
            end
            epw_pkg::PS_PARAM: begin
               // saturate so surplus parameters fall on no slot
               if (paramIdx_q != 2'd3) begin
                  paramIdx_d = paramIdx_q + 2'd1;
               end
               unique case (cmd_q)
                  `EPW_CMD_GATE_WIDTH: begin
                     if (paramIdx_q == 2'd0) begin
                        gate_d = hostByte.data[6:0];
                     end
                  end
                  `EPW_CMD_BORDER: begin
                     if (paramIdx_q == 2'd0) begin
                        border_d = hostByte.data & `EPW_BORDER_MASK;
                     end
                  end
                  `EPW_CMD_X_WINDOW: begin
                     if (paramIdx_q == 2'd0) begin
                        win_d.xStart = hostByte.data[4:0];
                     end else if (paramIdx_q == 2'd1) begin
                        win_d.xEnd = hostByte.data[4:0];
                     end
                  end
                  `EPW_CMD_Y_WINDOW: begin
                     if (paramIdx_q == 2'd0) begin
                        win_d.yStart = hostByte.data;
                     end else if (paramIdx_q == 2'd1) begin
                        win_d.yEnd = hostByte.data;
                     end
                  end
                  `EPW_CMD_X_COUNTER: begin
                     loadX = (paramIdx_q == 2'd0);
                  end
                  `EPW_CMD_Y_COUNTER: begin
                     loadY = (paramIdx_q == 2'd0);
                  end
                  default: begin
                     // commands outside this block: parameters dropped
                  end
               endcase
            end
            default: begin
               // data before any command is ignored
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= epw_pkg::PS_IDLE;
         cmd_q <= 8'h00;
         paramIdx_q <= 2'd0;
         gate_q <= `EPW_GATE_WIDTH_RST;
         border_q <= `EPW_BORDER_RST;
         win_q.xStart <= `EPW_X_START_RST;
         win_q.xEnd <= `EPW_X_END_RST;
         win_q.yStart <= `EPW_Y_START_RST;
         win_q.yEnd <= `EPW_Y_END_RST;
         ramWr_q <= '0;
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         paramIdx_q <= paramIdx_d;
         gate_q <= gate_d;
         border_q <= border_d;
         win_q <= win_d;
         ramWr_q <= ramWr_d;
      end
   end

   epw_addr_counter addrCounter (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .window(win_q),
      .loadX(loadX),
      .loadY(loadY),
      .loadValue(hostByte.data),
      .advance(advance),
      .xCount(xCount),
      .yCount(yCount)
   );

   ////////////////////////////////////////////////////////////////////////////
   // border drive selection

   logic ctrlInit_q, ctrlInit_d;
   epw_pkg::epw_border_t bd_q, bd_d;

   always_comb begin
      if (ctrlInit_q && border_q[`EPW_BORDER_FOLLOW_BIT]) begin
         // low bits are overridden for the initial stage only
         bd_d.mode = epw_pkg::BM_FOLLOW;
         bd_d.level = sourceLevel;
      end else if (border_q[`EPW_BORDER_FIX_BIT]) begin
         bd_d.mode = epw_pkg::BM_FIXED;
         bd_d.level = border_q[5:4];
      end else begin
         bd_d.mode = epw_pkg::BM_TRANSITION;
         bd_d.level = border_q[1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bd_q.mode <= epw_pkg::BM_TRANSITION;
         bd_q.level <= 2'(`EPW_BORDER_RST);
      end else begin
         bd_q <= bd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave

   logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [7:0] awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0] wStrb_q, wStrb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   epw_pkg::epw_reg_t rSel;

   assign awready = !awHeld_q && !bvalid_q;
   assign wready = !wHeld_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign rSel = regSel(araddr);

   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d = wHeld_q;
      awAddr_d = awAddr_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bvalid_d = bvalid_q && !bready;
      bresp_d = bresp_q;
      ctrlInit_d = ctrlInit_q;
      if (awvalid && awready) begin
         awHeld_d = 1'b1;
         awAddr_d = awaddr;
      end
      if (wvalid && wready) begin
         wHeld_d = 1'b1;
         wData_d = wdata;
         wStrb_d = wstrb;
      end
      // only ctrl is writable; settings belong to the command stream
      if (awHeld_q && wHeld_q && !bvalid_q) begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bvalid_d = 1'b1;
         if (regSel(awAddr_q) == epw_pkg::R_CTRL) begin
            bresp_d = `EPW_RESP_OKAY;
            if (wStrb_q[0]) begin
               ctrlInit_d = wData_q[`EPW_CTRL_INIT_STAGE_BIT];
            end
         end else begin
            bresp_d = `EPW_RESP_SLVERR;
         end
      end
   end

   always_comb begin
      rvalid_d = rvalid_q && !rready;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (arvalid && arready) begin
         rvalid_d = 1'b1;
         rresp_d = `EPW_RESP_OKAY;
         rdata_d = 32'h0000_0000;
         unique case (rSel)
            epw_pkg::R_GATE: rdata_d[6:0] = gate_q;
            epw_pkg::R_BORDER: rdata_d[7:0] = border_q;
            epw_pkg::R_XWIN: rdata_d[12:0] = {win_q.xEnd, 3'b000, win_q.xStart};
            epw_pkg::R_YWIN: rdata_d[15:0] = {win_q.yEnd, win_q.yStart};
            epw_pkg::R_ADDR: rdata_d[15:0] = {yCount, 3'b000, xCount};
            epw_pkg::R_STATUS: rdata_d[15:0] = {cmd_q, 6'b00_0000, state_q};
            epw_pkg::R_CTRL: rdata_d[0] = ctrlInit_q;
            epw_pkg::R_NONE: rresp_d = `EPW_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `EPW_RESP_OKAY;
         ctrlInit_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= `EPW_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         awAddr_q <= awAddr_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         ctrlInit_q <= ctrlInit_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;
   assign borderDriveOutput = bd_q;
   assign ramWrite = ramWr_q;
   assign gateLineWidth = gate_q;
   assign window = win_q;

endmodule

// ==== sim/epw_cmd_decoder_sva.sv ====
`timescale 1ns/100ps
module epw_cmd_decoder_sva (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // watched ports
   input wire epw_pkg::epw_host_byte_t hostByte,
   input wire epw_pkg::epw_border_t borderDriveOutput,
   input wire epw_pkg::epw_ram_wr_t ramWrite,
   input wire logic [6:0] gateLineWidth,
   input wire epw_pkg::epw_window_t window
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // a command byte directly followed by its first parameter
   sequence cmdThen(logic [7:0] c);
      hostByte.valid && !hostByte.isData && hostByte.data == c
      ##1 hostByte.valid && hostByte.isData;
   endsequence
   sequence param;
      hostByte.valid && hostByte.isData;
   endsequence

   reset_values_a: assert property (
      $rose(rst_n) |-> gateLineWidth == 7'h0B && borderDriveOutput == 4'h1
      && window == {5'h00, 5'h0F, 8'h00, 8'hF9})
      else $error("settings not at reset values");
   gate_width_a: assert property (
      cmdThen(8'h3A) |=> gateLineWidth == $past(hostByte.data[6:0]))
      else $error("gate width not taken");
   border_fixed_a: assert property (
      cmdThen(8'h3B) ##0 (hostByte.data[6] && !hostByte.data[7]) |-> ##2
      borderDriveOutput == {epw_pkg::BM_FIXED, $past(hostByte.data[5:4], 2)})
      else $error("fixed border level wrong");
   border_trans_a: assert property (
      cmdThen(8'h3B) ##0 (hostByte.data[7:6] == 2'b00) |-> ##2
      borderDriveOutput == {epw_pkg::BM_TRANSITION,
      $past(hostByte.data[1:0], 2)})
      else $error("border transition wrong");
   x_window_a: assert property (
      cmdThen(8'h44) ##1 param |=>
      window.xStart == $past(hostByte.data[4:0], 2)
      && window.xEnd == $past(hostByte.data[4:0]))
      else $error("x window wrong");
   y_window_a: assert property (
      cmdThen(8'h45) ##1 param |=>
      window.yStart == $past(hostByte.data, 2)
      && window.yEnd == $past(hostByte.data))
      else $error("y window wrong");
   x_load_a: assert property (
      cmdThen(8'h4E) ##1 cmdThen(8'h24) |=>
      ramWrite.x == $past(hostByte.data[4:0], 3))
      else $error("x counter not loaded");
   y_load_a: assert property (
      cmdThen(8'h4F) ##1 cmdThen(8'h4E) ##1 cmdThen(8'h24) |=>
      ramWrite.y == $past(hostByte.data, 5))
      else $error("y counter not loaded");
   ram_write_a: assert property (
      cmdThen(8'h24) |=> ramWrite.en && ramWrite.data == $past(hostByte.data))
      else $error("ram byte not written");
   ram_advance_a: assert property (
      ramWrite.en ##1 ramWrite.en |-> ramWrite.x ==
      ($past(ramWrite.x) == window.xEnd ? window.xStart
      : $past(ramWrite.x) + 5'h01))
      else $error("x pointer did not advance");
endmodule

bind epw_cmd_decoder epw_cmd_decoder_sva sva_u (.core_clk(core_clk),
   .rst_n(rst_n), .hostByte(hostByte), .borderDriveOutput(borderDriveOutput),
   .ramWrite(ramWrite), .gateLineWidth(gateLineWidth), .window(window));

// ==== sim/epw_host_model.sv ====
`timescale 1ns/100ps
module epw_host_model (
   // clock
   input wire logic core_clk,
   // byte stream to the decoder
   output epw_pkg::epw_host_byte_t hostByte
);
   initial hostByte = '0;
   // command with isData low, parameters high, sent in call order
   task automatic put(input logic isD, input logic [7:0] d);
      @(posedge core_clk);
      hostByte <= '{valid: 1'b1, isData: isD, data: d};
   endtask
   // idle bus shows inverted leftovers so stale bytes never look held
   task automatic idle();
      @(posedge core_clk);
      hostByte <= '{1'b0, ~hostByte.isData, ~hostByte.data};
   endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/100ps
module tb;
   logic core_clk, rst_n;
   logic [1:0] sourceLevel, bresp, rresp;
   epw_pkg::epw_host_byte_t hostByte;
   epw_pkg::epw_border_t borderDriveOutput;
   epw_pkg::epw_ram_wr_t ramWrite;
   logic [6:0] gateLineWidth;
   epw_pkg::epw_window_t window;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   int num_errors, n_tests, cycles;

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   epw_cmd_decoder dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .hostByte(hostByte), .sourceLevel(sourceLevel),
      .borderDriveOutput(borderDriveOutput), .ramWrite(ramWrite),
      .gateLineWidth(gateLineWidth), .window(window), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   epw_host_model host_u (.core_clk(core_clk), .hostByte(hostByte));

   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         ad = ad | awready;
         wd = wd | wready;
      end while (!(ad && wd));
      do @(posedge core_clk); while (!bvalid);
      bready <= 1'b0;
      check("bresp", 32'(bresp), 32'(er));
   endtask

   task automatic axiRead(input logic [7:0] a, input logic [31:0] exp,
         input logic [1:0] er, input string what);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (!rvalid);
      rready <= 1'b0;
      check(what, rdata, exp);
      check("rresp", 32'(rresp), 32'(er));
   endtask

   task automatic send(input logic [7:0] c, input int n, input logic [7:0] p0,
         p1);
      host_u.put(1'b0, c);
      if (n > 0) host_u.put(1'b1, p0);
      if (n > 1) host_u.put(1'b1, p1);
   endtask

   // border output lags the byte by two edges
   task automatic settle();
      host_u.idle();
      repeat (3) @(posedge core_clk);
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         test_done();
      end
   end

   initial begin
      rst_n = 1'b0;
      sourceLevel = 2'b00;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      axiRead(8'h00, 32'h0000_000B, 2'h0, "gate");
      axiRead(8'h04, 32'h0000_0001, 2'h0, "border");
      axiRead(8'h08, 32'h0000_0F00, 2'h0, "xwin");
      axiRead(8'h0C, 32'h0000_F900, 2'h0, "ywin");
      axiRead(8'h10, 32'h0000_0000, 2'h0, "counters");
      axiRead(8'h1C, 32'h0000_0000, 2'h2, "unmapped");
      check("border out", 32'(borderDriveOutput), 32'h0000_0001);
      $display("test reset done");
      send(8'h3A, 1, 8'h25, 8'h00);
      send(8'h3B, 1, 8'h5E, 8'h00);
      send(8'h44, 2, 8'h03, 8'h0A);
      send(8'h45, 2, 8'h10, 8'h20);
      settle();
      check("gate", 32'(gateLineWidth), 32'h0000_0025);
      check("border out", 32'(borderDriveOutput), 32'h0000_0005);
      axiRead(8'h04, 32'h0000_0052, 2'h0, "border");
      check("window", 32'(window), 32'({5'h03, 5'h0A, 8'h10, 8'h20}));
      send(8'h3B, 1, 8'h02, 8'h00);
      settle();
      check("border out", 32'(borderDriveOutput), 32'h0000_0002);
      $display("test settings done");
      send(8'h4F, 1, 8'h1F, 8'h00);
      send(8'h4E, 1, 8'h09, 8'h00);
      send(8'h24, 2, 8'hA1, 8'hA2);
      host_u.put(1'b1, 8'hA3);
      send(8'h3A, 2, 8'h11, 8'h55);
      settle();
      axiRead(8'h10, 32'h0000_2004, 2'h0, "counters");
      // last command code and parser left in parameter state
      axiRead(8'h14, 32'h0000_3A01, 2'h0, "status");
      check("gate", 32'(gateLineWidth), 32'h0000_0011);
      $display("test ram done");
      sourceLevel <= 2'b10;
      axiWrite(8'h18, 32'h0000_0001, 2'h0);
      axiWrite(8'h00, 32'h0000_007F, 2'h2);
      axiRead(8'h18, 32'h0000_0001, 2'h0, "ctrl");
      axiRead(8'h00, 32'h0000_0011, 2'h0, "gate");
      // bit6 set too: follow must override the fixed level
      send(8'h3B, 1, 8'hD1, 8'h00);
      settle();
      check("mode", 32'(borderDriveOutput.mode), 32'(epw_pkg::BM_FOLLOW));
      check("border out", 32'(borderDriveOutput), 32'h0000_000A);
      // byte lane 0 off: ctrl must keep its value
      wstrb <= 4'hE;
      axiWrite(8'h18, 32'h0000_0000, 2'h0);
      axiRead(8'h18, 32'h0000_0001, 2'h0, "ctrl");
      wstrb <= 4'hF;
      axiWrite(8'h18, 32'h0000_0000, 2'h0);
      repeat (2) @(posedge core_clk);
      check("border out", 32'(borderDriveOutput), 32'h0000_0005);
      $display("test follow done");
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      axiRead(8'h00, 32'h0000_000B, 2'h0, "gate");
      axiRead(8'h18, 32'h0000_0000, 2'h0, "ctrl");
      axiRead(8'h10, 32'h0000_0000, 2'h0, "counters");
      check("window", 32'(window), 32'({5'h00, 5'h0F, 8'h00, 8'hF9}));
      check("border out", 32'(borderDriveOutput), 32'h0000_0001);
      $display("test second reset done");
      test_done();
   end
endmodule
